// File: hw/bar_display_pkg.sv
// package for the bar graph segment driver: offsets, fields, counts.
// assumes a single pclk domain at 200 MHz and an apb master outside.
package bar_display_pkg;

    // segment geometry
    localparam int SEG_COUNT = 41;            // zero segment plus forty
    localparam int SEG_MAX = 40;              // highest data segment index
    localparam int CNT_W = 6;                 // width of a conversion count

    // measurement cycle timing in divided-clock counts
    localparam int CYCLE_COUNTS = 80;         // counts per conversion
    localparam int DRIVE_TOGGLES = 10;        // plane toggles per conversion
    localparam int TOGGLE_COUNTS = CYCLE_COUNTS / DRIVE_TOGGLES;
    localparam int PRESCALE_DEF = 32;         // pclk cycles per count

    // register byte offsets
    localparam logic [11:0] CTRL_OFS = 12'h000;   // control
    localparam logic [11:0] RESULT_OFS = 12'h004; // conversion input
    localparam logic [11:0] STATUS_OFS = 12'h008; // shown state
    localparam logic [11:0] SEGLO_OFS = 12'h00c;  // segments 0..31
    localparam logic [11:0] SEGHI_OFS = 12'h010;  // segments 32..40
    localparam logic [11:0] PRESC_OFS = 12'h014;  // count prescaler

    // control field positions
    localparam int CTRL_DOT_N = 0;    // low selects dot mode
    localparam int CTRL_HOLD_N = 1;   // low selects hold
    localparam int CTRL_TEST_N = 2;   // low selects test pattern
    localparam logic [31:0] CTRL_RST = 32'h0000_0007;

    // result field positions
    localparam int RES_NEG = 8;       // sign of the conversion
    localparam logic [15:0] PRESC_RST = 16'h0020;

    // one latched conversion as shown on the glass
    typedef struct packed {
        logic [CNT_W-1:0] count;  // segment index
        logic negative;           // sign
        logic over;               // out of range
    } shown_type;

    // phases of the measurement cycle
    typedef enum logic [1:0] {
        PH_ZERO,
        PH_SIGNAL,
        PH_REFER
    } phase_type;

endpackage : bar_display_pkg

// File: hw/segment_pattern.sv
// segment_pattern: turns a shown conversion into the on/off pattern.
// assumes the inputs are registered by the caller; purely combinational.
module segment_pattern
(
    input wire bar_display_pkg::shown_type shown,
    input wire logic dot_mode,
    input wire logic test_mode,
    input wire logic flash_off,
    output logic [bar_display_pkg::SEG_COUNT-1:0] seg_on,
    output logic sign_on,
    output logic over_on
);
    import bar_display_pkg::*;
    // one lit segment per index, filled or single
    genvar g;
    generate
        for (g = 0; g < SEG_COUNT; g++) begin : gen_seg
            // bar lights the index and all below, dot just the index
            wire logic at_idx = (shown.count == CNT_W'(g));
            wire logic below = (shown.count > CNT_W'(g));
            wire logic lit = test_mode ? 1'b1 :
                dot_mode ? at_idx : (at_idx | below);
            assign seg_on[g] = lit & ~(shown.over & flash_off);
        end
    endgenerate

    // sign and overrange indicators
    assign sign_on = test_mode | shown.negative;
    assign over_on = (test_mode | shown.over) & ~flash_off;
endmodule : segment_pattern

// File: hw/bar_display.sv
// bar_display: static lcd bar graph driver with apb control.
// assumes pclk at 200 MHz, apb master on the same clock, glass on pins.
// Operation
// - forty data segments plus one zero segment
// - bar mode lights index and all below
// - dot mode lights only the index segment
// - sign segment on for negative input
// - overrange flashes display and indicator
// - hold freezes the shown pattern
// - off in phase, on inverted to plane
// - drive toggles ten times per conversion
// - one static output per segment, one plane
// - fill-style defaults to bar, low selects dot
// - hold inactive by default, low holds
// - test forces full bar except in overrange blank phase, flashing overrange, sign
// - measurement cycle is fixed eighty counts
//
// Register access over APB and the register offsets were chosen for this implementation.
module bar_display
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clk_en,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic common_plane_drive,
    output logic [bar_display_pkg::SEG_COUNT-1:0] segment_drive,
    output logic negative_sign_segment,
    output logic overrange_segment,
    output logic conversion_done
);
    import bar_display_pkg::*;

    // software state
    logic [31:0] ctrl_q;              // control bits, active low fields
    logic [CNT_W-1:0] result_q;       // magnitude offered by the converter
    logic result_neg_q;               // sign offered by the converter
    logic [15:0] presc_q;             // pclk cycles per count

    // timing state
    logic [15:0] div_q;               // prescaler counter
    logic [6:0] count_q;              // count within the cycle
    logic [3:0] tog_q;                // counts since the last plane toggle
    logic plane_q;                    // plane phase
    logic [3:0] flash_q;              // toggles since the last flash flip
    logic flash_q_off;                // flash blank phase
    phase_type phase_q;               // current measurement phase
    shown_type shown_q;               // latched display register

    // bus decode as named wires
    wire logic access = psel & penable;
    wire logic wr = access & pwrite;
    wire logic hit_ctrl = (paddr == CTRL_OFS);
    wire logic hit_res = (paddr == RESULT_OFS);
    wire logic hit_stat = (paddr == STATUS_OFS);
    wire logic hit_lo = (paddr == SEGLO_OFS);
    wire logic hit_hi = (paddr == SEGHI_OFS);
    wire logic hit_presc = (paddr == PRESC_OFS);
    wire logic mapped = hit_ctrl | hit_res | hit_stat | hit_lo | hit_hi |
        hit_presc;

    // mode levels; reset value keeps bar and no hold and no test
    wire logic dot_mode = ~ctrl_q[CTRL_DOT_N];
    wire logic hold_mode = ~ctrl_q[CTRL_HOLD_N];
    wire logic test_mode = ~ctrl_q[CTRL_TEST_N];

    // timing strobes
    // at or past the last step ends a count, so shrinking the prescaler
    // mid-count cannot strand the divider on a long wrap
    wire logic div_last = (div_q >= 16'(presc_q - 16'h0001));
    wire logic tick = clk_en && div_last;
    wire logic cycle_end = tick && (count_q == 7'(CYCLE_COUNTS - 1));
    wire logic toggle = tick && (tog_q == 4'(TOGGLE_COUNTS - 1));
    wire logic flash_step = toggle && (flash_q == 4'(DRIVE_TOGGLES - 1));

    // pattern for the glass
    logic [SEG_COUNT-1:0] seg_on;
    logic sign_on;
    logic over_on;
    segment_pattern u_pattern (
        .shown(shown_q),
        .dot_mode(dot_mode),
        .test_mode(test_mode),
        .flash_off(flash_q_off),
        .seg_on(seg_on),
        .sign_on(sign_on),
        .over_on(over_on)
    );

    // next display register: counts above the top mean overrange
    shown_type next_shown;
    assign next_shown.over = (result_q > CNT_W'(SEG_MAX));
    assign next_shown.count = next_shown.over ? CNT_W'(SEG_MAX) : result_q;
    assign next_shown.negative = result_neg_q;

    // read mux
    logic [31:0] rdata_d;
    assign rdata_d = hit_ctrl ? ctrl_q :
        hit_res ? {23'h0, result_neg_q, 2'h0, result_q} :
        hit_stat ? {20'h0, phase_q, flash_q_off, plane_q, shown_q} :
        hit_lo ? seg_on[31:0] :
        hit_hi ? {23'h0, seg_on[SEG_COUNT-1:32]} :
        hit_presc ? {16'h0, presc_q} : 32'h0;

    // register writes
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q <= CTRL_RST;
            result_q <= '0;
            result_neg_q <= 1'b0;
            presc_q <= PRESC_RST;
        end else if (clk_en && wr) begin
            if (hit_ctrl) begin
                ctrl_q <= {29'h0, pwdata[2:0]};
            end
            if (hit_res) begin
                result_q <= pwdata[CNT_W-1:0];
                result_neg_q <= pwdata[RES_NEG];
            end
            if (hit_presc && pwdata[15:0] != 16'h0) begin
                presc_q <= pwdata[15:0];
            end
        end
    end

    // apb answer registered, no wait states
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            prdata <= '0;
            pslverr <= 1'b0;
        end else if (clk_en) begin
            pready <= psel & ~penable;
            prdata <= rdata_d;
            pslverr <= psel & ~penable & ~mapped;
        end
    end

    // prescaler and fixed-length measurement cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_q <= '0;
            count_q <= '0;
        end else if (clk_en) begin
            div_q <= tick ? 16'h0 : 16'(div_q + 16'h0001);
            if (tick) begin
                count_q <= cycle_end ? 7'h0 : 7'(count_q + 7'h01);
            end
        end
    end

    // phase tracking: signal integrate is the fixed middle stretch
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            phase_q <= PH_ZERO;
        end else if (tick) begin
            case (phase_q)
                PH_ZERO: if (count_q == 7'h27) phase_q <= PH_SIGNAL;
                PH_SIGNAL: if (count_q == 7'h3b) phase_q <= PH_REFER;
                PH_REFER: if (cycle_end) phase_q <= PH_ZERO;
                default: phase_q <= PH_ZERO;
            endcase
        end
    end

    // plane toggle and flash timing
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tog_q <= '0;
            plane_q <= 1'b0;
            flash_q <= '0;
            flash_q_off <= 1'b0;
        end else if (tick) begin
            tog_q <= toggle ? 4'h0 : 4'(tog_q + 4'h1);
            if (toggle) begin
                plane_q <= ~plane_q;
                flash_q <= flash_step ? 4'h0 : 4'(flash_q + 4'h1);
            end
            if (flash_step) begin
                flash_q_off <= ~flash_q_off;
            end
        end
    end

    // display register updates at cycle end unless held
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            shown_q <= '0;
            conversion_done <= 1'b0;
        end else if (clk_en) begin
            conversion_done <= cycle_end;
            if (cycle_end && !hold_mode) begin
                shown_q <= next_shown;
            end
        end
    end

    // static drive: each segment its own output against one plane
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            common_plane_drive <= 1'b0;
            segment_drive <= '0;
            negative_sign_segment <= 1'b0;
            overrange_segment <= 1'b0;
        end else if (clk_en) begin
            common_plane_drive <= plane_q;
            segment_drive <= {SEG_COUNT{plane_q}} ^ seg_on;
            negative_sign_segment <= plane_q ^ sign_on;
            overrange_segment <= plane_q ^ over_on;
        end
    end

    // off segments follow the plane, on segments oppose it
    phase_drive_a: assert property (@(posedge pclk) disable iff (!presetn)
        presetn && clk_en |=> segment_drive == ({SEG_COUNT{$past(plane_q)}}
        ^ $past(seg_on))) else $error("segment phase wrong");

    // hold keeps display register
    hold_freeze_a: assert property (@(posedge pclk) disable iff (!presetn)
        hold_mode && $past(hold_mode) |-> $stable(shown_q))
        else $error("display changed in hold");

    // latch on cycle end
    cycle_latch_a: assert property (@(posedge pclk) disable iff (!presetn)
        cycle_end && !hold_mode |=> shown_q == $past(next_shown))
        else $error("display not latched");

    // count never passes the cycle length
    cycle_len_a: assert property (@(posedge pclk) disable iff (!presetn)
        count_q < 7'(CYCLE_COUNTS)) else $error("cycle too long");

    // overrange register state pins the count at the top
    over_flag_a: assert property (@(posedge pclk) disable iff (!presetn)
        shown_q.over |-> shown_q.count == CNT_W'(SEG_MAX))
        else $error("overrange count wrong");

    // sign follows shown sign or test
    sign_drive_a: assert property (@(posedge pclk) disable iff (!presetn)
        presetn && clk_en |=> negative_sign_segment == ($past(plane_q)
        ^ ($past(test_mode) | $past(shown_q.negative))))
        else $error("sign drive wrong");

    // dot mode lights at most one data segment
    dot_single_a: assert property (@(posedge pclk) disable iff (!presetn)
        dot_mode && !test_mode |-> $onehot0(seg_on))
        else $error("dot mode lit many");

    // bar mode fill is contiguous from zero
    bar_fill_a: assert property (@(posedge pclk) disable iff (!presetn)
        !dot_mode && !test_mode && !flash_q_off |->
        ((seg_on + 41'h1) & seg_on) == 41'h0)
        else $error("bar not contiguous");

    // plane toggles only on toggle strobe
    plane_rate_a: assert property (@(posedge pclk) disable iff (!presetn)
        !toggle |=> $stable(plane_q)) else $error("plane moved");

    // test lights every data segment outside the flash blank
    test_full_a: assert property (@(posedge pclk) disable iff (!presetn)
        test_mode && !(shown_q.over && flash_q_off) |-> &seg_on)
        else $error("test pattern incomplete");

    // forced bar mode by default
    bar_default_a: assert property (@(posedge pclk) disable iff (!presetn)
        ctrl_q[CTRL_DOT_N] |-> !dot_mode) else $error("bad default");

    // hold only from low bit
    hold_level_a: assert property (@(posedge pclk) disable iff (!presetn)
        hold_mode == !ctrl_q[CTRL_HOLD_N]) else $error("hold sense");

    // static drive: plane output follows plane state
    plane_out_a: assert property (@(posedge pclk) disable iff (!presetn)
        presetn && clk_en |=> common_plane_drive == $past(plane_q))
        else $error("plane out wrong");

    // overrange line follows plane and blinking indicator
    over_drive_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        presetn && clk_en |=> overrange_segment == ($past(plane_q)
        ^ (($past(test_mode) | $past(shown_q.over)) & !$past(flash_q_off))))
        else $error("overrange drive wrong");

    // dot mode lights the shown index outside the flash blank
    dot_index_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        dot_mode && !test_mode && !(shown_q.over && flash_q_off)
        |-> seg_on[shown_q.count])
        else $error("dot index dark");

    // plane toggle counter stays inside one toggle span
    toggle_span_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        tog_q < 4'(TOGGLE_COUNTS))
        else $error("toggle span overrun");

    // blank phase moves only on the flash step
    flash_step_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        !flash_step |=> $stable(flash_q_off))
        else $error("flash moved early");

    // end of conversion is a single pulse
    done_pulse_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        conversion_done && clk_en |=> !conversion_done)
        else $error("done too long");

    // display register moves only at a conversion end
    shown_change_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        !cycle_end |=> $stable(shown_q))
        else $error("display moved mid cycle");

    // segment lines stand still while the enable is low
    drive_freeze_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        !clk_en |=> $stable(segment_drive))
        else $error("drive moved while frozen");

    // test keeps the sign segment lit
    test_sign_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        test_mode |-> sign_on)
        else $error("test sign dark");
endmodule : bar_display

// File: verification/lcd_glass.sv
// lcd_glass: static glass model, one plane facing one line per segment.
// assumes drive levels settle one pclk after each plane edge.
module lcd_glass
    import bar_display_pkg::*;
(
    input wire logic clk,
    input wire logic plane,
    input wire logic [SEG_COUNT-1:0] seg,
    input wire logic sign,
    input wire logic over,
    output logic [SEG_COUNT-1:0] lit,
    output logic sign_lit,
    output logic over_lit
);
    timeunit 1ns;
    timeprecision 1ps;
    logic plane_q; // plane one cycle back, marks the edge cycle
    // a segment shows where its line stands opposite the plane
    always @(posedge clk) begin
        plane_q <= plane;
        // skip the edge cycle so a lagging line is not misread
        if (plane_q == plane) begin
            lit <= seg ^ {SEG_COUNT{plane}};
            sign_lit <= sign ^ plane;
            over_lit <= over ^ plane;
        end
    end
endmodule : lcd_glass

// File: verification/bar_display_tb.sv
// bar_display_tb: self-checking bench, apb master plus glass model.
// assumes the package constants and a 200 MHz pclk.
module bar_display_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import bar_display_pkg::*;
    logic pclk = 0;
    logic presetn = 0;
    logic clk_en = 1;
    logic psel = 0;
    logic penable = 0;
    logic pwrite = 0;
    logic [11:0] paddr = '0;
    logic [31:0] pwdata = '0;
    logic [31:0] prdata;
    logic pready, pslverr, plane, sign_d, over_d, done;
    logic [SEG_COUNT-1:0] seg_d, lit;
    logic sign_lit, over_lit;
    int num_errors = 0;
    int tests_run = 0;
    bar_display dut (.pclk(pclk), .presetn(presetn), .clk_en(clk_en),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .common_plane_drive(plane),
        .segment_drive(seg_d), .negative_sign_segment(sign_d),
        .overrange_segment(over_d), .conversion_done(done));
    lcd_glass glass (.clk(pclk), .plane(plane), .seg(seg_d),
        .sign(sign_d), .over(over_d), .lit(lit), .sign_lit(sign_lit),
        .over_lit(over_lit));
    // 5 ns clock
    initial begin
        forever #2.5 pclk = ~pclk;
    end
    // value compare
    task chk(input string what, input logic [63:0] exp,
        input logic [63:0] got);
        tests_run++;
        if (got !== exp) begin
            num_errors++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    // one apb transfer, held until pready is sampled high
    task apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
        output logic [31:0] rd, output logic err);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1;
        penable <= 0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        @(posedge pclk);
        while (pready !== 1'b1 && n < 50) begin
            @(posedge pclk);
            n++;
        end
        if (n >= 50) num_errors++;
        rd = prdata;
        err = pslverr;
        psel <= 0;
        penable <= 0;
    endtask : apb
    task wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        apb(1'b1, a, d, r, e);
    endtask : wr
    task rdc(input string what, input logic [11:0] a,
        input logic [31:0] exp);
        logic [31:0] r;
        logic e;
        apb(1'b0, a, 32'h0, r, e);
        chk(what, exp, r);
    endtask : rdc
    // wait for one end-of-conversion pulse, bounded
    task wait_done;
        int n;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (done !== 1'b1 && n < 2000);
        if (n >= 2000) num_errors++;
    endtask : wait_done
    // two conversions so a new value is latched and on the glass
    task settle;
        wait_done();
        wait_done();
        repeat (4) @(posedge pclk);
    endtask : settle
    function automatic logic [SEG_COUNT-1:0] bar(input int n);
        bar = '0;
        for (int i = 0; i <= n; i++) bar[i] = 1'b1;
    endfunction : bar
    // watch four conversions, tallying what the glass showed
    task watch(output int full, output int blank, output int ov_on,
        output int ov_off);
        full = 0;
        blank = 0;
        ov_on = 0;
        ov_off = 0;
        repeat (320) begin
            @(posedge pclk);
            if (lit === bar(SEG_MAX)) full++;
            if (lit === '0) blank++;
            if (over_lit === 1'b1) ov_on++;
            if (over_lit === 1'b0) ov_off++;
        end
    endtask : watch
    task t_reset;
        logic [31:0] r;
        logic e;
        rdc("ctrl reset", CTRL_OFS, CTRL_RST);
        rdc("presc reset", PRESC_OFS, {16'h0, PRESC_RST});
        apb(1'b0, 12'h0f0, 32'h0, r, e);
        chk("unmapped err", 1, e);
        chk("unmapped data", 0, r);
        wr(PRESC_OFS, 32'h1);
        wr(PRESC_OFS, 32'h0);
        rdc("presc zero kept", PRESC_OFS, 32'h1);
    endtask : t_reset
    task t_bar_dot;
        int vals[3] = '{0, 17, 40};
        logic [SEG_COUNT-1:0] m;
        foreach (vals[i]) begin
            m = bar(vals[i]);
            wr(RESULT_OFS, vals[i]);
            settle();
            chk("bar lit", m, lit);
            chk("sign off", 0, sign_lit);
            chk("over off", 0, over_lit);
            rdc("seg low", SEGLO_OFS, m[31:0]);
            rdc("seg high", SEGHI_OFS, {23'h0, m[40:32]});
            wr(CTRL_OFS, 32'h6);
            wr(RESULT_OFS, 32'h100 | vals[i]);
            settle();
            chk("dot lit", 41'h1 << vals[i], lit);
            chk("sign on", 1, sign_lit);
            wr(CTRL_OFS, 32'h7);
        end
    endtask : t_bar_dot
    task t_hold;
        logic [31:0] r;
        logic e;
        wr(RESULT_OFS, 10);
        settle();
        wr(CTRL_OFS, 32'h5);
        wr(RESULT_OFS, 30);
        settle();
        chk("held lit", bar(10), lit);
        apb(1'b0, STATUS_OFS, 32'h0, r, e);
        chk("status held", 8'h28, r[7:0]);
        wr(CTRL_OFS, 32'h7);
        settle();
        chk("released lit", bar(30), lit);
    endtask : t_hold
    task t_over_test;
        int f, b, on, off;
        wr(RESULT_OFS, 41);
        settle();
        watch(f, b, on, off);
        chk("over full seen", 1, f > 0);
        chk("over blank seen", 1, b > 0);
        chk("over seg on", 1, on > 0);
        chk("over seg off", 1, off > 0);
        wr(RESULT_OFS, 3);
        wr(CTRL_OFS, 32'h3);
        settle();
        watch(f, b, on, off);
        chk("test full", 320, f);
        chk("test over flash", 1, on > 0 && off > 0);
        chk("test sign", 1, sign_lit);
        wr(CTRL_OFS, 32'h7);
    endtask : t_over_test
    task t_timing;
        int n, edges;
        logic p;
        wait_done();
        n = 0;
        edges = 0;
        p = plane;
        do begin
            @(posedge pclk);
            n++;
            if (plane !== p) edges++;
            p = plane;
        end while (done !== 1'b1 && n < 1000);
        chk("cycle length", CYCLE_COUNTS, n);
        chk("plane toggles", DRIVE_TOGGLES, edges);
    endtask : t_timing
    // enable low must freeze the plane and the done pulse
    task t_freeze;
        logic p, d;
        int moved;
        moved = 0;
        @(posedge pclk);
        clk_en <= 1'b0;
        @(posedge pclk);
        p = plane;
        d = done;
        repeat (200) begin
            @(posedge pclk);
            if (plane !== p || done !== d) moved++;
        end
        clk_en <= 1'b1;
        chk("frozen plane", 0, moved);
    endtask : t_freeze
    task wrap_up;
        if (num_errors == 0 && tests_run > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : wrap_up
    // watchdog well past the expected run of about fourteen microseconds
    initial begin
        #300000;
        num_errors++;
        wrap_up();
    end
    // main sequence
    initial begin
        repeat (12) @(posedge pclk);
        presetn <= 1;
        t_reset();
        t_bar_dot();
        t_hold();
        t_over_test();
        t_freeze();
        t_timing();
        wrap_up();
    end
endmodule : bar_display_tb
